// ---- shared/adc_serial_pkg.sv ----
// ****************************************************************
// Constants and carriers of the serial converter control logic
// ****************************************************************
package adc_serial_pkg;

    // Result, address and counter widths.
    localparam int unsigned RESULT_W = 10;
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned CNT_W    = 5;

    // Shift-clock edge counts that steer a transfer.
    localparam logic [4:0] ADDR_LAST_RISE  = 5'h03;  // Rise count before the fourth rise.
    localparam logic [4:0] SAMPLE_FALL     = 5'h03;  // Fall count before the fourth fall.
    localparam logic [4:0] LSB_FALL        = 5'h09;  // Fall count before the tenth fall.
    localparam logic [4:0] TEN_EDGES       = 5'h0A;  // Ten edges seen.
    localparam logic [4:0] LAST_FALL       = 5'h0F;  // Fall count before the sixteenth fall.
    localparam logic [4:0] MAX_EDGES       = 5'h10;  // Sixteen edges, counters saturate.

    // Highest valid source code: eleven inputs plus three self-test levels.
    localparam logic [3:0] SRC_CODE_MAX    = 4'hD;

    // Reset values.
    localparam logic       DONE_RESET      = 1'h1;
    localparam logic [9:0] RESULT_RESET    = 10'h000;
    localparam logic [3:0] ADDR_RESET      = 4'h0;

    // Conversion duration in system clocks, chosen default.
    localparam int unsigned CONV_CYCLES    = 100;

    // Pins of the host serial port, as seen at the device.
    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic addr;
    } pins_t;

    // Transfer control states.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_TAIL  = 3'b100
    } xfer_state_t;

endpackage : adc_serial_pkg

// ---- rtl/pin_sync.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Two-stage synchroniser for asynchronous pin levels
// ****************************************************************
module pin_sync #(
    parameter int unsigned WIDTH = 3
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             resetn_i,
    // Levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // Each bit passes two flops; the first stage feeds only the second.
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic meta_q;
        logic stable_q;
        always_ff @(posedge sys_clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                meta_q   <= 1'b1;
                stable_q <= 1'b1;
            end
            else
            begin
                meta_q   <= async_i[i];
                stable_q <= meta_q;
            end
        end
        assign sync_o[i] = stable_q;
    end

endmodule : pin_sync

// ---- rtl/conv_timer.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Conversion duration timer
// ****************************************************************
module conv_timer #(
    parameter int unsigned CYCLES = adc_serial_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic resetn_i,
    // Control
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          done_q;
    logic          done_d;

    // A start while busy restarts the count; the converter has one sample only.
    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start_i)
            cnt_d = CW'(CYCLES);
        else if (cnt_q != '0)
        begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == CW'(1));
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != '0);
    assign done_o = done_q;

endmodule : conv_timer

// ---- rtl/adc_serial_ctrl.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Serial output tri-stated while chip select high, driven while low.
// - MSB of previous result first; next bits on falls, LSB on ninth.
// - Tenth shift-clock fall forces the serial output low.
// - Done output falls at tenth fall, rises when conversion result ready.
// - First four rises capture address; multiplexer address valid after fourth.
// - Sampling runs from fourth fall to tenth fall, then sample held.
// - Conversion starts only at tenth fall; fewer clocks start nothing.
// - Chip select high ignores clock and address; its fall starts transfer.
// - MSB at select fall, done rise, or after sixteenth fall by mode.
// - Fast mode means transfer ends before conversion; ten clocks always fast.
// - Select fall resets counters; select rise disables inputs within two clocks.
// - Address picks one of fourteen sources, codes zero to thirteen.
module adc_serial_ctrl #(
    parameter int unsigned CONV_CYCLES = adc_serial_pkg::CONV_CYCLES
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    // Host serial pins
    input  wire logic        cs_n_i,
    input  wire logic        sclk_i,
    input  wire logic        addr_i,
    output logic             dout_o,
    output logic             dout_oe_o,
    output logic             done_o,
    // Analog core side
    input  wire logic [9:0]  conv_data_i,
    output logic      [3:0]  mux_sel_o,
    output logic             src_valid_o,
    output logic             sampling_o,
    output logic             hold_o
);

    // ****************************************************************
    // Pin synchronisation and edge detection
    // ****************************************************************
    adc_serial_pkg::pins_t pins_async;
    adc_serial_pkg::pins_t pins_s;
    logic                  cs_low_prev_q;
    logic                  sclk_prev_q;
    logic                  cs_low;
    logic                  cs_fall;
    logic                  sclk_rise;
    logic                  sclk_fall;

    assign pins_async = '{cs_n: cs_n_i, sclk: sclk_i, addr: addr_i};

    pin_sync #(
        .WIDTH ($bits(adc_serial_pkg::pins_t))
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .async_i   (pins_async),
        .sync_o    (pins_s)
    );

    // Edges are qualified by chip select, so a high select blocks the clock.
    assign cs_low    = ~pins_s.cs_n;
    assign cs_fall   = cs_low & ~cs_low_prev_q;
    assign sclk_rise = cs_low & pins_s.sclk & ~sclk_prev_q;
    assign sclk_fall = cs_low & ~pins_s.sclk & sclk_prev_q;

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cs_low_prev_q <= 1'b0;
            sclk_prev_q   <= 1'b0;
        end
        else
        begin
            cs_low_prev_q <= cs_low;
            sclk_prev_q   <= pins_s.sclk;
        end
    end

    // ****************************************************************
    // Conversion timer
    // ****************************************************************
    logic conv_start_q;
    logic conv_start_d;
    logic conv_done;

    conv_timer #(
        .CYCLES (CONV_CYCLES)
    ) u_timer (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .start_i   (conv_start_q),
        .busy_o    (),
        .done_o    (conv_done)
    );

    // ****************************************************************
    // Transfer control
    // ****************************************************************
    adc_serial_pkg::xfer_state_t state_q;
    adc_serial_pkg::xfer_state_t state_d;
    logic [4:0] rise_cnt_q;
    logic [4:0] rise_cnt_d;
    logic [4:0] fall_cnt_q;
    logic [4:0] fall_cnt_d;
    logic [9:0] shreg_q;
    logic [9:0] shreg_d;
    logic [9:0] result_q;
    logic [9:0] result_d;
    logic [3:0] addr_sh_q;
    logic [3:0] addr_sh_d;
    logic [3:0] mux_sel_q;
    logic [3:0] mux_sel_d;
    logic       ready_q;
    logic       ready_d;
    logic       dout_q;
    logic       dout_d;
    logic       dout_oe_q;
    logic       dout_oe_d;
    logic       done_q;
    logic       done_d;
    logic       sampling_q;
    logic       sampling_d;
    logic       hold_q;
    logic       hold_d;
    logic       fast_end;
    logic       slow_end;
    logic       restart;
    logic [9:0] load_val;

    // A conversion that finishes after the transfer has ended is a fast one;
    // ten clocks with select held low, or a full sixteen, end it there.
    assign fast_end = cs_low & conv_done &
                      (((rise_cnt_q == adc_serial_pkg::TEN_EDGES) &&
                        (fall_cnt_q == adc_serial_pkg::TEN_EDGES)) ||
                       (fall_cnt_q == adc_serial_pkg::MAX_EDGES));
    // In the slow held-select mode the sixteenth fall opens the next sequence.
    assign slow_end = sclk_fall & ready_q & (state_q == adc_serial_pkg::ST_TAIL) &
                      (fall_cnt_q == adc_serial_pkg::LAST_FALL);
    assign restart  = cs_fall | fast_end | slow_end;
    // A freshly finished result bypasses the result register on restart.
    assign load_val = conv_done ? conv_data_i : result_q;

    always_comb
    begin
        state_d      = state_q;
        rise_cnt_d   = rise_cnt_q;
        fall_cnt_d   = fall_cnt_q;
        shreg_d      = shreg_q;
        result_d     = result_q;
        addr_sh_d    = addr_sh_q;
        mux_sel_d    = mux_sel_q;
        ready_d      = ready_q;
        dout_d       = dout_q;
        dout_oe_d    = dout_oe_q;
        done_d       = done_q;
        sampling_d   = sampling_q;
        hold_d       = 1'b0;
        conv_start_d = 1'b0;

        // End of conversion: result latched and done raised.
        if (conv_done)
        begin
            result_d = conv_data_i;
            done_d   = 1'b1;
            ready_d  = 1'b1;
        end

        if (!cs_low)
        begin
            // Select high: output released, nothing shifts.
            state_d    = adc_serial_pkg::ST_IDLE;
            dout_oe_d  = 1'b0;
            sampling_d = 1'b0;
        end
        else if (restart)
        begin
            // New sequence: counters cleared, previous MSB presented at once.
            state_d    = adc_serial_pkg::ST_SHIFT;
            rise_cnt_d = '0;
            fall_cnt_d = '0;
            addr_sh_d  = adc_serial_pkg::ADDR_RESET;
            shreg_d    = load_val;
            dout_d     = load_val[9];
            dout_oe_d  = 1'b1;
            ready_d    = 1'b0;
            sampling_d = 1'b0;
        end
        else
        begin
            dout_oe_d = 1'b1;
            if (sclk_rise && (rise_cnt_q != adc_serial_pkg::MAX_EDGES))
            begin
                rise_cnt_d = rise_cnt_q + 5'h01;
                // Only the first four rises read the address line.
                if (rise_cnt_q <= adc_serial_pkg::ADDR_LAST_RISE)
                    addr_sh_d = {addr_sh_q[2:0], pins_s.addr};
                if (rise_cnt_q == adc_serial_pkg::ADDR_LAST_RISE)
                    mux_sel_d = {addr_sh_q[2:0], pins_s.addr};
            end
            if (sclk_fall && (fall_cnt_q != adc_serial_pkg::MAX_EDGES))
            begin
                fall_cnt_d = fall_cnt_q + 5'h01;
                if (fall_cnt_q < adc_serial_pkg::LSB_FALL)
                begin
                    shreg_d = {shreg_q[8:0], 1'b0};
                    dout_d  = shreg_q[8];
                end
                if (fall_cnt_q == adc_serial_pkg::SAMPLE_FALL)
                    sampling_d = 1'b1;
                if (fall_cnt_q == adc_serial_pkg::LSB_FALL)
                begin
                    state_d      = adc_serial_pkg::ST_TAIL;
                    dout_d       = 1'b0;
                    sampling_d   = 1'b0;
                    hold_d       = 1'b1;
                    done_d       = 1'b0;
                    ready_d      = 1'b0;
                    conv_start_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_q      <= adc_serial_pkg::ST_IDLE;
            rise_cnt_q   <= '0;
            fall_cnt_q   <= '0;
            shreg_q      <= adc_serial_pkg::RESULT_RESET;
            result_q     <= adc_serial_pkg::RESULT_RESET;
            addr_sh_q    <= adc_serial_pkg::ADDR_RESET;
            mux_sel_q    <= adc_serial_pkg::ADDR_RESET;
            ready_q      <= 1'b0;
            dout_q       <= 1'b0;
            dout_oe_q    <= 1'b0;
            done_q       <= adc_serial_pkg::DONE_RESET;
            sampling_q   <= 1'b0;
            hold_q       <= 1'b0;
            conv_start_q <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            rise_cnt_q   <= rise_cnt_d;
            fall_cnt_q   <= fall_cnt_d;
            shreg_q      <= shreg_d;
            result_q     <= result_d;
            addr_sh_q    <= addr_sh_d;
            mux_sel_q    <= mux_sel_d;
            ready_q      <= ready_d;
            dout_q       <= dout_d;
            dout_oe_q    <= dout_oe_d;
            done_q       <= done_d;
            sampling_q   <= sampling_d;
            hold_q       <= hold_d;
            conv_start_q <= conv_start_d;
        end
    end

    // Codes above thirteen select nothing; the flag is registered with the code.
    logic src_valid_q;
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            src_valid_q <= 1'b1;
        else
            src_valid_q <= (mux_sel_d <= adc_serial_pkg::SRC_CODE_MAX);
    end

    // Outputs straight from flops.
    assign dout_o      = dout_q;
    assign dout_oe_o   = dout_oe_q;
    assign done_o      = done_q;
    assign mux_sel_o   = mux_sel_q;
    assign src_valid_o = src_valid_q;
    assign sampling_o  = sampling_q;
    assign hold_o      = hold_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic tenth_fall;
    logic fourth_rise;
    assign tenth_fall  = sclk_fall & ~restart & (fall_cnt_q == adc_serial_pkg::LSB_FALL);
    assign fourth_rise = sclk_rise & ~restart & (rise_cnt_q == adc_serial_pkg::ADDR_LAST_RISE);

    property p_release;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !cs_low |=> !dout_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("output driven with select high");

    property p_msb_first;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        cs_fall |=> dout_oe_o && (dout_o == $past(load_val[9]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("MSB not shown on select fall");

    property p_tenth_low;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        tenth_fall && !conv_done |=> !dout_o && !done_o && conv_start_q ##1 !done_o;
    endproperty
    a_tenth_low: assert property (p_tenth_low) else $error("tenth fall did not end data");

    property p_start_only_tenth;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        conv_start_q |-> $past(fall_cnt_q) == adc_serial_pkg::LSB_FALL && $past(sclk_fall);
    endproperty
    a_start_only_tenth: assert property (p_start_only_tenth) else $error("early start");

    property p_done_rise;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(done_o) |-> $past(conv_done) && (result_q == $past(conv_data_i));
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done rose without result");

    property p_addr_load;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        fourth_rise |=> mux_sel_o == {$past(addr_sh_q[2:0]), $past(pins_s.addr)};
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not applied");

    property p_sample_start;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        $rose(sampling_o) |-> $past(fall_cnt_q) == adc_serial_pkg::SAMPLE_FALL;
    endproperty
    a_sample_start: assert property (p_sample_start) else $error("sampling began off edge");

    property p_ignore_high;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !cs_low |=> $stable(mux_sel_o) && $stable(fall_cnt_q);
    endproperty
    a_ignore_high: assert property (p_ignore_high) else $error("inputs used with select high");

    property p_fast_msb;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        fast_end && cs_low |=> dout_o == $past(conv_data_i[9]) ##1 done_o;
    endproperty
    a_fast_msb: assert property (p_fast_msb) else $error("MSB not shown on done rise");

    c_tenth: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) tenth_fall);
    c_fast:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i) fast_end);
    c_slow:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i) slow_end);

endmodule : adc_serial_ctrl

// ---- sim/host_port_model.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Host serial port master: select, shift clock and address
// ****************************************************************
module host_port_model (
    // Clock
    input  wire logic sys_clk_i,
    // Device pins seen by the host
    input  wire logic dout_i,
    input  wire logic done_i,
    // Host pins
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      addr_o
);
    logic [15:0] got;
    logic        dn_low;

    // Select idle high; the shift clock idles low, and only stray pulses it outside frames.
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        addr_o = 1'b0;
        dn_low = 1'b0;
    end

    // Half a shift-clock period of 160 ns, leaving just after a clock edge.
    task automatic half();
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask : half

    // Bounded wait for the done pin, so a dead device cannot hang the host.
    task automatic wait_done();
        for (int w = 0; w < 4000 && done_i !== 1'b1; w++)
        begin
            @(posedge sys_clk_i);
        end
        #1;
    endtask : wait_done

    // One shift clock; the result bit is taken at the rise, a slow host stalls after rise 11.
    task automatic pulse(input int k, input logic a, input bit slow);
        addr_o = a;
        half();
        sclk_o = 1'b1;
        got[16-k] = dout_i;
        if (slow && k == 11)
        begin
            wait_done();
        end
        half();
        sclk_o = 1'b0;
    endtask : pulse

    // A whole transfer; past bit four the address line toggles so stale levels show.
    task automatic xfer(input int n, input logic [3:0] adr, input bit slow, input bit keep);
        got = 16'h0000;
        cs_n_o = 1'b0;
        for (int k = 1; k <= n; k++)
        begin
            pulse(k, (k <= 4) ? adr[4-k] : ~addr_o, slow);
            if (k == 10)
            begin
                half();
                dn_low = (done_i === 1'b0);
            end
        end
        if (!keep)
        begin
            half();
            cs_n_o = 1'b1;
        end
        wait_done();
        half();
    endtask : xfer

    // Shift clocks with select high, which the device must ignore.
    task automatic stray(input int n);
        repeat (n) pulse(12, ~addr_o, 1'b0);
    endtask : stray
endmodule : host_port_model

// ---- sim/tb.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench of the serial converter control
// ****************************************************************
module tb;
    localparam int CONV = 120;

    logic       sys_clk_i;
    logic       resetn_i;
    logic       cs_n;
    logic       sclk;
    logic       addr;
    logic       dout_o;
    logic       dout_oe_o;
    logic       done_o;
    logic [9:0] conv_data;
    logic [3:0] mux_sel_o;
    logic       src_valid_o;
    logic       sampling_o;
    logic       hold_o;
    wire logic  dout_w;
    logic [9:0] prev;
    logic       samp_q   = 1'b0;
    int         hold_cnt = 0;
    int         error_cnt;
    int         compares;

    // The data pin floats whenever the device lets go of it.
    assign dout_w = dout_oe_o ? dout_o : 1'bz;

    adc_serial_ctrl #(.CONV_CYCLES(CONV)) i_dut (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .addr_i(addr), .dout_o(dout_o), .dout_oe_o(dout_oe_o), .done_o(done_o),
        .conv_data_i(conv_data), .mux_sel_o(mux_sel_o), .src_valid_o(src_valid_o),
        .sampling_o(sampling_o), .hold_o(hold_o)
    );

    host_port_model i_host (
        .sys_clk_i(sys_clk_i), .dout_i(dout_w), .done_i(done_o),
        .cs_n_o(cs_n), .sclk_o(sclk), .addr_o(addr)
    );

    // Counts held samples that closed a sampling window.
    always @(posedge sys_clk_i)
    begin
        samp_q <= sampling_o;
        if (hold_o === 1'b1 && samp_q === 1'b1)
        begin
            hold_cnt <= hold_cnt + 1;
        end
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    // One transfer and everything it should leave behind.
    task automatic xfer_chk(input int n, input logic [3:0] adr, input bit slow, input bit keep,
                            input logic [9:0] nxt);
        int h0;
        conv_data = nxt;
        h0 = hold_cnt;
        i_host.xfer(n, adr, slow, keep);
        check(i_host.got, {prev, 6'h00} & ~(16'hFFFF >> n));
        check(mux_sel_o, adr);
        check(src_valid_o, adr <= 4'hD);
        check(16'(hold_cnt - h0), n >= 10);
        check(done_o, 1'b1);
        check(dout_w, keep ? nxt[9] : 1'bz);
        if (n >= 10)
        begin
            check(i_host.dn_low, 1'b1);
            prev = nxt;
        end
    endtask : xfer_chk

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        check(done_o, 1'b1);
        check(dout_w, 1'bz);
        check(mux_sel_o, 4'h0);
    endtask : t_reset

    // Short transfer starts nothing; clocks with select high change nothing.
    task automatic t_short();
        int h0;
        xfer_chk(8, 4'h9, 1'b0, 1'b0, 10'h3C3);
        h0 = hold_cnt;
        i_host.stray(12);
        check(mux_sel_o, 4'h9);
        check(16'(hold_cnt - h0), 16'h0000);
        check(dout_w, 1'bz);
    endtask : t_short

    task automatic t_cs_high_modes();
        xfer_chk(10, 4'hB, 1'b0, 1'b0, 10'h2A5);
        t_short();
        xfer_chk(13, 4'hE, 1'b0, 1'b0, 10'h1C3);
        xfer_chk(14, 4'h5, 1'b1, 1'b0, 10'h3FF);
    endtask : t_cs_high_modes

    // Select held low: restarts on done for 10 and 16 clocks, on fall 16 when slow.
    task automatic t_cs_low_modes();
        xfer_chk(10, 4'hA, 1'b0, 1'b1, 10'h155);
        xfer_chk(10, 4'hC, 1'b0, 1'b1, 10'h0F0);
        xfer_chk(16, 4'hD, 1'b0, 1'b1, 10'h30C);
        xfer_chk(16, 4'h0, 1'b0, 1'b1, 10'h0A6);
        xfer_chk(16, 4'h1, 1'b1, 1'b1, 10'h2D2);
        xfer_chk(16, 4'h7, 1'b1, 1'b0, 10'h11E);
    endtask : t_cs_low_modes

    // ****************************************************************
    // Clock, reset, sequence and watchdog
    // ****************************************************************
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    initial
    begin
        resetn_i = 1'b0;
        conv_data = 10'h000;
        prev = 10'h000;
        error_cnt = 0;
        compares = 0;
        repeat (2) @(posedge sys_clk_i);
        #1;
        resetn_i = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        t_reset();
        t_cs_high_modes();
        t_cs_low_modes();
        close_out();
    end

    // The run needs about 3200 cycles; a hang is cut off well beyond that.
    initial
    begin
        repeat (60000) @(posedge sys_clk_i);
        error_cnt++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
endmodule : tb
